// ==== hw/config_word_decoder.sv ====
/*
 * Configuration word decoder: holds the device configuration word, decodes
 * it into clock, watchdog, delay, brown-out and protection settings, and
 * runs the reset hold-off, watchdog and sleep wake-up sequencing.
 * Assumes an APB master on core_clk, asynchronous pins for programming
 * mode, clock input, external reset and brown-out detect, and same-clock
 * sleep, watchdog clear and interrupt requests from the core.
 */
// Operation
// - configuration word sits at index 2007h
// - programmed bit reads 0, unprogrammed 1
// - test space reachable only in programming mode
// - two bits select the oscillator mode
// - bit 2 set turns watchdog on
// - bit 3 low enables power-up delay
// - bit 6 set enables brown-out reset
// - brown-out enable forces power-up delay on
// - protection pairs encode protected memory share
// - bit 7 always reads back one
// - only configuration can stop the watchdog
// - watchdog runs from its own divided tick
// - power-up delay holds reset 72 ms
// - start-up timer holds reset until oscillator stable
// - sleep ends on reset, watchdog or interrupt
// - start-up timer counts 1024 clock-input edges
`timescale 1ns/1ps
`default_nettype none

module config_word_decoder #(
    parameter int POWERUP_CYCLES = config_word_pkg::POWERUP_DELAY_CYCLES,
    parameter int WATCHDOG_TICKS = config_word_pkg::WATCHDOG_PERIOD_TICKS
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire config_word_pkg::apb_req_type apb_req,
    output var config_word_pkg::apb_rsp_type apb_rsp,
    input wire logic prog_mode_pin,
    input wire logic clock_input_pin,
    input wire logic mclr_b_pin,
    input wire logic brownout_detect_pin,
    input wire logic sleep_req,
    input wire logic watchdog_clear,
    input wire logic irq_wake,
    output var config_word_pkg::settings_type settings,
    output logic chip_reset_hold,
    output logic watchdog_reset,
    output logic sleeping
);
    import config_word_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [3:0] pin_s0;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [3:0] pin_f;
        logic clk_prev;
        logic [13:0] word;
        settings_type cfg;
        phase_type phase;
        logic [22:0] delay_cnt;
        logic [9:0] ost_cnt;
        logic [6:0] wdt_div;
        logic [15:0] wdt_cnt;
        apb_rsp_type rsp;
        logic hold;
        logic wdt_rst;
        logic asleep;
    } state_type;

    state_type state_reg;
    state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic settings_type decode_word(input logic [13:0] w);
        settings_type s;
        logic [1:0] p0;
        logic consistent;
        p0 = w[PROTECT_PAIR0_POS +: 2];
        consistent = (w[PROTECT_PAIR1_POS +: 2] == p0)
            && (w[PROTECT_PAIR2_POS +: 2] == p0)
            && (w[PROTECT_PAIR3_POS +: 2] == p0);
        s.osc_mode = osc_mode_type'(w[OSC_SELECT_LO_POS +: 2]);
        s.watchdog_enable = w[WATCHDOG_ENABLE_POS];
        s.powerup_delay_enable_n = w[POWERUP_DELAY_ENABLE_N_POS];
        s.brownout_enable = w[BROWNOUT_ENABLE_POS];
        // mismatched pairs select no scheme, so memory stays open
        s.protect_level = consistent ? p0 : 2'h3;
        s.protect_consistent = consistent;
        return s;
    endfunction

    logic [29:0] bus_idx;
    logic in_test_space;
    logic prog_mode;
    logic mclr_low;
    logic brownout_active;
    logic delay_on;
    logic crystal;
    logic clk_edge;
    logic wdt_tick;
    logic wdt_timeout;
    logic [31:0] read_data;
    logic read_err;
    phase_type resume_phase;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;

        // pin synchronisers: a change is taken once stages two and three agree
        state_next.pin_s0 = {brownout_detect_pin, mclr_b_pin, clock_input_pin,
            prog_mode_pin};
        state_next.pin_s1 = state_reg.pin_s0;
        state_next.pin_s2 = state_reg.pin_s1;
        for (int i = 0; i < 4; i++) begin
            if (state_reg.pin_s1[i] == state_reg.pin_s2[i]) begin
                state_next.pin_f[i] = state_reg.pin_s2[i];
            end
        end
        prog_mode = state_reg.pin_f[0];
        mclr_low = ~state_reg.pin_f[2];
        brownout_active = state_reg.cfg.brownout_enable & state_reg.pin_f[3];

        // an external clock on the pin counts the same as a crystal
        clk_edge = state_reg.pin_f[1] & ~state_reg.clk_prev;
        state_next.clk_prev = state_reg.pin_f[1];

        delay_on = ~state_reg.cfg.powerup_delay_enable_n
            | state_reg.cfg.brownout_enable;
        crystal = (state_reg.cfg.osc_mode != RC_MODE);
        resume_phase = crystal ? PH_OSC_STARTUP : PH_RUN;

        // watchdog on its own slow tick, free of core activity
        wdt_tick = (state_reg.wdt_div == 7'(WATCHDOG_OSC_DIV - 1));
        state_next.wdt_div = wdt_tick ? 7'h00 : state_reg.wdt_div + 7'h01;
        wdt_timeout = 1'b0;
        if (!state_reg.cfg.watchdog_enable) begin
            state_next.wdt_cnt = 16'h0000;
        end else if (watchdog_clear || state_reg.hold) begin
            state_next.wdt_cnt = 16'h0000;
        end else if (wdt_tick) begin
            if (state_reg.wdt_cnt == 16'(WATCHDOG_TICKS - 1)) begin
                wdt_timeout = 1'b1;
                state_next.wdt_cnt = 16'h0000;
            end else begin
                state_next.wdt_cnt = state_reg.wdt_cnt + 16'h0001;
            end
        end

        // reset sequencing
        unique case (state_reg.phase)
            PH_POWERUP_DELAY: begin
                if (!delay_on || state_reg.delay_cnt == 23'(POWERUP_CYCLES - 1)) begin
                    state_next.phase = resume_phase;
                    state_next.ost_cnt = 10'h000;
                end else begin
                    state_next.delay_cnt = state_reg.delay_cnt + 23'h000001;
                end
            end
            PH_OSC_STARTUP: begin
                if (clk_edge) begin
                    if (state_reg.ost_cnt == 10'(OSC_STARTUP_EDGES - 1)) begin
                        state_next.phase = PH_RUN;
                    end else begin
                        state_next.ost_cnt = state_reg.ost_cnt + 10'h001;
                    end
                end
            end
            PH_RUN: begin
                if (mclr_low || wdt_timeout) begin
                    state_next.phase = PH_EXT_RESET;
                end else if (sleep_req) begin
                    state_next.phase = PH_SLEEP;
                end
            end
            PH_SLEEP: begin
                if (mclr_low) begin
                    state_next.phase = PH_EXT_RESET;
                end else if (wdt_timeout || irq_wake) begin
                    state_next.phase = resume_phase;
                    state_next.ost_cnt = 10'h000;
                end
            end
            PH_EXT_RESET: begin
                if (!mclr_low) begin
                    state_next.phase = PH_RUN;
                end
            end
            default: begin
                state_next.phase = PH_POWERUP_DELAY;
                state_next.delay_cnt = 23'h000000;
            end
        endcase
        if (brownout_active) begin
            state_next.phase = PH_POWERUP_DELAY;
            state_next.delay_cnt = 23'h000000;
        end
        state_next.hold = (state_next.phase != PH_RUN)
            && (state_next.phase != PH_SLEEP);
        state_next.asleep = (state_next.phase == PH_SLEEP);
        state_next.wdt_rst = wdt_timeout && (state_reg.phase == PH_RUN);

        // bus decode
        bus_idx = apb_req.paddr[31:2];
        in_test_space = (bus_idx >= TEST_SPACE_LO_IDX)
            && (bus_idx <= TEST_SPACE_HI_IDX);
        read_data = 32'h0000_0000;
        read_err = 1'b0;
        if (bus_idx == STATUS_IDX) begin
            read_data = {24'h000000, state_reg.asleep, state_reg.cfg.protect_consistent,
                prog_mode, state_reg.cfg.watchdog_enable, state_reg.hold,
                state_reg.phase};
        end else if (in_test_space && prog_mode) begin
            if (bus_idx == CFG_WORD_IDX) begin
                read_data = {18'h00000, state_reg.word};
                read_data[UNIMPLEMENTED_POS] = 1'b1;
            end
        end else begin
            read_err = 1'b1;
        end

        // one wait state, then the access completes
        state_next.rsp.pready = 1'b0;
        if (apb_req.psel && apb_req.penable && !state_reg.rsp.pready) begin
            state_next.rsp.pready = 1'b1;
            state_next.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : read_data;
            state_next.rsp.pslverr = read_err;
        end
        if (apb_req.psel && apb_req.penable && state_reg.rsp.pready
            && apb_req.pwrite && !read_err && bus_idx == CFG_WORD_IDX) begin
            state_next.word = apb_req.pwdata[13:0];
            state_next.word[UNIMPLEMENTED_POS] = 1'b1;
            state_next.cfg = decode_word(apb_req.pwdata[13:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= '0;
            // every stage starts with mclr released, brown-out flagged and the clock pin low, so no false clock edge follows reset
            state_reg.pin_s0 <= 4'hc;
            state_reg.pin_s1 <= 4'hc;
            state_reg.pin_s2 <= 4'hc;
            state_reg.pin_f <= 4'hc;
            state_reg.word <= CFG_ERASED;
            state_reg.cfg <= decode_word(CFG_ERASED);
            state_reg.phase <= PH_POWERUP_DELAY;
            state_reg.hold <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign apb_rsp = state_reg.rsp;
    assign settings = state_reg.cfg;
    assign chip_reset_hold = state_reg.hold;
    assign watchdog_reset = state_reg.wdt_rst;
    assign sleeping = state_reg.asleep;

endmodule

`default_nettype wire

// ==== hw/config_word_pkg.sv ====
/*
 * Shared constants and types of the configuration word decoder:
 * register indices, field positions, reset values, timing counts and the
 * bus and settings carriers.
 * Assumes a 100 MHz core clock and an APB master with 32-bit data.
 */
package config_word_pkg;

    // register indices; byte address is four times the index
    localparam logic [29:0] CFG_WORD_IDX = 30'h0000_2007;
    localparam logic [29:0] TEST_SPACE_LO_IDX = 30'h0000_2000;
    localparam logic [29:0] TEST_SPACE_HI_IDX = 30'h0000_3fff;
    localparam logic [29:0] STATUS_IDX = 30'h0000_0010;

    // field positions inside the configuration word
    localparam int OSC_SELECT_LO_POS = 0;
    localparam int WATCHDOG_ENABLE_POS = 2;
    localparam int POWERUP_DELAY_ENABLE_N_POS = 3;
    localparam int PROTECT_PAIR0_POS = 4;
    localparam int BROWNOUT_ENABLE_POS = 6;
    localparam int UNIMPLEMENTED_POS = 7;
    localparam int PROTECT_PAIR1_POS = 8;
    localparam int PROTECT_PAIR2_POS = 10;
    localparam int PROTECT_PAIR3_POS = 12;

    // every bit unprogrammed
    localparam logic [13:0] CFG_ERASED = 14'h3fff;

    // timing
    localparam int CORE_CLK_MHZ = 100;
    localparam int POWERUP_DELAY_US = 72000;
    localparam int POWERUP_DELAY_CYCLES = POWERUP_DELAY_US * CORE_CLK_MHZ;
    localparam int OSC_STARTUP_EDGES = 1024;
    localparam int WATCHDOG_OSC_DIV = 100;
    localparam int WATCHDOG_PERIOD_TICKS = 18000;

    typedef enum logic [1:0] {
        LOW_POWER_CRYSTAL_MODE = 2'h0,
        STANDARD_CRYSTAL_MODE = 2'h1,
        HIGH_SPEED_CRYSTAL_MODE = 2'h2,
        RC_MODE = 2'h3
    } osc_mode_type;

    typedef enum logic [2:0] {
        PH_POWERUP_DELAY = 3'h0,
        PH_OSC_STARTUP = 3'h1,
        PH_RUN = 3'h2,
        PH_SLEEP = 3'h3,
        PH_EXT_RESET = 3'h4
    } phase_type;

    typedef struct packed {
        osc_mode_type osc_mode;
        logic watchdog_enable;
        logic powerup_delay_enable_n;
        logic brownout_enable;
        logic [1:0] protect_level;
        logic protect_consistent;
    } settings_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;

endpackage

// ==== sim/programmer_model.sv ====
/* device programmer model: drives the register bus and the programming pin.
   assumes core_clk from the bench and the decoder's apb slave. */
`timescale 1ns/1ps
`default_nettype none
module programmer_model
    import config_word_pkg::*;
(
    input wire logic core_clk,
    output var config_word_pkg::apb_req_type apb_req,
    input wire config_word_pkg::apb_rsp_type apb_rsp,
    output var logic prog_mode_pin
);
    initial begin
        apb_req = '0;
        prog_mode_pin = 1'b0;
    end
    ////////////////////////////////////////
    // one transfer; the bench watchdog cuts a missing answer short
    task automatic xfer(input logic wr, input logic [29:0] idx, input logic [31:0] wdata,
        output logic [31:0] rdata, output logic err);
        apb_req <= '{1'b1, 1'b0, wr, {idx, 2'h0}, wdata};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        @(posedge core_clk);
        while (apb_rsp.pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge core_clk);
    endtask
    // the pin filter needs a few cycles to follow
    task automatic set_prog(input logic on);
        prog_mode_pin <= on;
        repeat (8) @(posedge core_clk);
    endtask
    // one protection code copied into every pair
    task automatic burn(input logic [13:0] w);
        logic [31:0] rd;
        logic err;
        xfer(1'b1, CFG_WORD_IDX, {18'h0, {3{w[5:4]}}, w[7:0]}, rd, err);
    endtask
endmodule
`default_nettype wire

// ==== sim/config_word_sva.sv ====
/* port checker of the configuration word decoder.
   bound to every config_word_decoder instance. */
`timescale 1ns/1ps
`default_nettype none
module config_word_sva
    import config_word_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire config_word_pkg::apb_req_type apb_req,
    input wire config_word_pkg::apb_rsp_type apb_rsp,
    input wire logic prog_mode_pin,
    input wire logic irq_wake,
    input wire config_word_pkg::settings_type settings,
    input wire logic watchdog_reset,
    input wire logic sleeping
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic [29:0] idx;
    logic [13:0] wd;
    logic [3:0] prog_low;
    assign idx = apb_req.paddr[31:2];
    assign wd = apb_req.pwdata[13:0];
    // cycles since the programming pin was last high
    always_ff @(posedge core_clk) begin
        if (!rst_b || prog_mode_pin) begin
            prog_low <= 4'h0;
        end else if (prog_low != 4'hf) begin
            prog_low <= prog_low + 4'h1;
        end
    end
    sequence cfg_ack(logic wr);
        apb_rsp.pready && !apb_rsp.pslverr && apb_req.pwrite == wr && idx == CFG_WORD_IDX;
    endsequence
    ////////////////////////////////////////
    a_osc_decode: assert property (cfg_ack(1'b1) |=> settings.osc_mode == $past(wd[1:0]))
        else $error("osc mode not decoded");
    a_wdt_decode: assert property (cfg_ack(1'b1) |=> settings.watchdog_enable == $past(wd[2]))
        else $error("watchdog enable not decoded");
    a_delay_decode: assert property (cfg_ack(1'b1) |=> settings.powerup_delay_enable_n == $past(wd[3]))
        else $error("delay enable not decoded");
    a_brownout_decode: assert property (cfg_ack(1'b1) |=> settings.brownout_enable == $past(wd[6]))
        else $error("brownout enable not decoded");
    a_protect_decode: assert property (cfg_ack(1'b1) ##0 wd[13:8] == {3{wd[5:4]}}
        |=> settings.protect_level == $past(wd[5:4]) && settings.protect_consistent)
        else $error("protection not decoded");
    a_bit7_one: assert property (cfg_ack(1'b0) |-> apb_rsp.prdata[7] && apb_rsp.prdata[31:14] == 18'h0)
        else $error("readback bits wrong");
    a_space_locked: assert property (apb_rsp.pready && prog_low == 4'hf
        && idx inside {[TEST_SPACE_LO_IDX:TEST_SPACE_HI_IDX]} |-> apb_rsp.pslverr)
        else $error("test space open outside programming");
    a_unmapped_err: assert property (apb_rsp.pready && idx != STATUS_IDX
        && !(idx inside {[TEST_SPACE_LO_IDX:TEST_SPACE_HI_IDX]}) |-> apb_rsp.pslverr)
        else $error("unmapped access accepted");
    a_settings_hold: assert property ($changed(settings) |-> $past(apb_rsp.pready
        && apb_req.pwrite && !apb_rsp.pslverr && idx == CFG_WORD_IDX))
        else $error("settings changed without a write");
    a_wdt_off: assert property (!settings.watchdog_enable [*2] |-> !watchdog_reset)
        else $error("disabled watchdog fired");
    a_irq_wakes: assert property (sleeping && irq_wake |-> ##[1:3] !sleeping)
        else $error("interrupt did not wake");
endmodule
bind config_word_decoder config_word_sva i_sva (.core_clk, .rst_b, .apb_req, .apb_rsp,
    .prog_mode_pin, .irq_wake, .settings, .watchdog_reset, .sleeping);
`default_nettype wire

// ==== sim/tb.sv ====
/* testbench of the configuration word decoder.
   assumes the programmer model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import config_word_pkg::*;
    localparam int POWERUP = 20;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clock_input_pin = 1'b0;
    logic osc_run = 1'b0;
    logic sleep_req = 1'b0;
    logic watchdog_clear = 1'b0;
    logic irq_wake = 1'b0;
    logic mclr_b_pin = 1'b1;
    logic brownout_detect_pin = 1'b0;
    logic prog_mode_pin;
    logic chip_reset_hold;
    logic watchdog_reset;
    logic sleeping;
    apb_req_type apb_req;
    apb_rsp_type apb_rsp;
    settings_type settings;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int total_checks = 0;
    always #5 core_clk = ~core_clk;
    // crystal stand-in, toggling only while osc_run is set for start-up
    always #20 clock_input_pin = osc_run ? ~clock_input_pin : clock_input_pin;
    config_word_decoder #(.POWERUP_CYCLES(POWERUP), .WATCHDOG_TICKS(5)) i_dut (
        .core_clk, .rst_b, .apb_req, .apb_rsp, .prog_mode_pin, .clock_input_pin,
        .mclr_b_pin, .brownout_detect_pin, .sleep_req, .watchdog_clear,
        .irq_wake, .settings, .chip_reset_hold, .watchdog_reset, .sleeping);
    programmer_model i_prog (.core_clk, .apb_req, .apb_rsp, .prog_mode_pin);
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_for(ref logic sig, input logic val, output int n);
        n = 0;
        while (sig !== val && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_powerup();
        int n;
        check("reset settings", 32'hff, settings);
        wait_for(chip_reset_hold, 1'b0, n);
        check("delay span", 1, n >= POWERUP && n <= POWERUP + 8);
    endtask
    task automatic t_refuse();
        i_prog.xfer(1'b0, CFG_WORD_IDX, 32'h0, rd, err);
        check("locked read", 1, err);
        i_prog.xfer(1'b1, CFG_WORD_IDX, 32'h0, rd, err);
        check("settings kept", 32'hff, settings);
        i_prog.xfer(1'b0, 30'h5, 32'h0, rd, err);
        check("unmapped", 1, err);
        i_prog.xfer(1'b0, STATUS_IDX, 32'h0, rd, err);
        check("status", 32'h52, rd);
    endtask
    task automatic t_program();
        logic [13:0] w;
        logic [1:0] cp;
        i_prog.set_prog(1'b1);
        for (int i = 0; i < 4; i++) begin
            cp = 2'(3 - i);
            w = {cp, cp, cp, 1'b0, ~i[0], cp, i[1], i[0], i[1:0]};
            i_prog.burn(w);
            check("settings", {24'h0, i[1:0], i[0], i[1], ~i[0], cp, 1'b1}, settings);
            i_prog.xfer(1'b0, CFG_WORD_IDX, 32'h0, rd, err);
            check("word", {18'h0, w | 14'h0080}, rd);
        end
        i_prog.xfer(1'b1, CFG_WORD_IDX, 32'h3fcf, rd, err);
        check("mixed pairs", 32'hfe, settings);
    endtask
    task automatic t_watchdog();
        int n;
        watchdog_clear <= 1'b1;
        @(posedge core_clk);
        watchdog_clear <= 1'b0;
        wait_for(watchdog_reset, 1'b1, n);
        check("timeout", 1, n >= 400 && n <= 510);
        i_prog.burn(14'h3ffb);
        n = 0;
        repeat (700) begin
            @(posedge core_clk);
            n += int'(watchdog_reset === 1'b1);
        end
        check("pulses when off", 0, n);
    endtask
    task automatic t_sleep();
        int n;
        i_prog.burn(14'h3ff9);
        sleep_req <= 1'b1;
        @(posedge core_clk);
        sleep_req <= 1'b0;
        wait_for(sleeping, 1'b1, n);
        check("asleep", 1, sleeping);
        irq_wake <= 1'b1;
        @(posedge core_clk);
        irq_wake <= 1'b0;
        wait_for(sleeping, 1'b0, n);
        check("irq wake", 1, n <= 3);
        osc_run = 1'b1;
        repeat (1023) @(posedge clock_input_pin);
        repeat (3) @(posedge core_clk);
        check("startup hold", 1, chip_reset_hold);
        wait_for(chip_reset_hold, 1'b0, n);
        check("startup end", 1, n >= 1 && n <= 10);
        osc_run = 1'b0;
    endtask
    task automatic t_resets();
        int n;
        mclr_b_pin <= 1'b0;
        @(posedge core_clk);
        wait_for(chip_reset_hold, 1'b1, n);
        check("mclr hold", 1, n <= 8);
        mclr_b_pin <= 1'b1;
        @(posedge core_clk);
        wait_for(chip_reset_hold, 1'b0, n);
        check("mclr release", 1, n <= 8);
        brownout_detect_pin <= 1'b1;
        @(posedge core_clk);
        wait_for(chip_reset_hold, 1'b1, n);
        check("brownout hold", 1, n <= 8);
        repeat (10) @(posedge core_clk);
        brownout_detect_pin <= 1'b0;
        repeat (POWERUP) @(posedge core_clk);
        check("brownout delay", 1, chip_reset_hold);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_powerup();
        t_refuse();
        t_program();
        t_watchdog();
        t_sleep();
        t_resets();
        test_done();
    end
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
